// ==== src/irc_pkg.sv ====
// irc_pkg: constants for the interrupt request controller.
// assumes an 8-bit memory-mapped register port with 16-bit addresses.
package irc_pkg;
    // register addresses
    localparam logic [15:0] FLAG_ADDR   = 16'hffe0;
    localparam logic [15:0] MASK_ADDR   = 16'hffe4;
    localparam logic [15:0] EDGE_ADDR   = 16'hffec;
    // reset values
    localparam logic [7:0]  FLAG_RESET  = 8'h00;
    localparam logic [7:0]  MASK_RESET  = 8'hff;
    localparam logic [1:0]  EDGE_RESET  = 2'h0;
    // edge select field position inside the edge config register
    localparam int          EDGE_LSB    = 2;
    // edge select codes
    localparam logic [1:0]  EDGE_FALL   = 2'h0;
    localparam logic [1:0]  EDGE_RISE   = 2'h1;
    localparam logic [1:0]  EDGE_BAD    = 2'h2;
    localparam logic [1:0]  EDGE_BOTH   = 2'h3;
    // source bit positions, also the default priority (0 highest)
    localparam int          SRC_WDT     = 0;
    localparam int          SRC_PIN     = 1;
    localparam int          SRC_SER     = 2;
    localparam int          SRC_WT      = 3;
    localparam int          SRC_TA      = 4;
    localparam int          SRC_TB      = 5;
    localparam int          SRC_KEY     = 6;
    localparam int          SRC_WTI     = 7;
    localparam int          NSRC        = 8;
    // vectors
    localparam logic [15:0] VEC_NMI     = 16'h0004;
    localparam logic [15:0] VEC_BASE    = 16'h0004;
    localparam logic [15:0] VEC_STEP    = 16'h0002;
    // ready line states
    typedef enum logic [1:0] {IRC_IDLE, IRC_MASK, IRC_NMI} irc_sel_t;
endpackage

// ==== src/irc_edge_detect.sv ====
// irc_edge_detect: valid-edge detector for the external pin request.
// assumes the pin level is synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module irc_edge_detect
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // pin and configuration
    input  wire logic       pin_level,
    input  wire logic [1:0] edge_sel,
    // detected edge
    output logic            edge_pulse
);
    logic prev_r;
    logic armed_r;
    // no history in the first cycle after reset, so a pin resting high
    // cannot fake a rising edge
    wire  rise_w = armed_r & pin_level & ~prev_r;
    wire  fall_w = armed_r & ~pin_level & prev_r;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_r  <= 1'b0;
            armed_r <= 1'b0;
        end
        else
        begin
            prev_r  <= pin_level;
            armed_r <= 1'b1;
        end
    end

    // prohibited code detects nothing rather than guessing an edge
    assign edge_pulse = (edge_sel == irc_pkg::EDGE_FALL) ? fall_w :
                        (edge_sel == irc_pkg::EDGE_RISE) ? rise_w :
                        (edge_sel == irc_pkg::EDGE_BOTH) ? (rise_w | fall_w) :
                        1'b0;
endmodule
`default_nettype wire

// ==== src/irc_top.sv ====
// irc_top: interrupt request controller, flags, masks, priority, vectors.
// assumes a CPU core that signals instruction ends, acknowledges, and
// holds the global accept bit inside its status word.
`timescale 1ns/1ps
`default_nettype none
module irc_top
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // byte register port
    input  wire logic [15:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata_r,
    // bit manipulation port
    input  wire logic        bit_wr,
    input  wire logic [15:0] bit_addr,
    input  wire logic [2:0]  bit_sel,
    input  wire logic        bit_val,
    // request sources, one-cycle pulses except the pin level and the watchdog mode level
    input  wire logic        watchdog_overflow_request,
    input  wire logic        wdt_interval_mode,
    input  wire logic        shared_port_pin,
    input  wire logic        serial_end_request,
    input  wire logic        watch_timer_request,
    input  wire logic        timer_a_match_request,
    input  wire logic        timer_b_match_request,
    input  wire logic        key_return_request,
    input  wire logic        watch_interval_request,
    // cpu core
    input  wire logic        global_accept_bit,
    input  wire logic        instr_done,
    input  wire logic        int_ack,
    output logic             int_req,
    output logic             int_nmi,
    output logic [15:0]      int_vector_r,
    output logic             status_push,
    output logic             accept_clear,
    output logic             standby_release
);
    localparam int NS = irc_pkg::NSRC;

    logic [NS-1:0] flag_r;
    logic [NS-1:0] flag_nxt;
    logic [NS-1:0] mask_r;
    logic [NS-1:0] mask_nxt;
    logic [1:0]    edge_r;
    logic          nmi_pend_r;
    logic          nmi_pend_nxt;
    irc_pkg::irc_sel_t sel_r;
    logic [2:0]    sel_idx_r;
    logic          pin_edge;
    logic [7:0]    pending_q;

    function automatic logic [2:0] prio_pick(input logic [7:0] req);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = NS - 1; i >= 0; i--)
            if (req[i])
                idx = 3'(i);
        return idx;
    endfunction

    function automatic logic [15:0] vec_of(input logic [2:0] idx);
        return irc_pkg::VEC_BASE + 16'(irc_pkg::VEC_STEP * 16'(idx));
    endfunction

    irc_edge_detect u_edge
    (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .pin_level  (shared_port_pin),
        .edge_sel   (edge_r),
        .edge_pulse (pin_edge)
    );

    // watchdog overflow goes to exactly one source
    wire wdt_nmi_evt = watchdog_overflow_request & ~wdt_interval_mode;
    wire wdt_msk_evt = watchdog_overflow_request & wdt_interval_mode;

    wire [NS-1:0] src_evt = {watch_interval_request, key_return_request,
                             timer_b_match_request, timer_a_match_request,
                             watch_timer_request, serial_end_request,
                             pin_edge, wdt_msk_evt};

    // register decode
    wire byte_flag = reg_wr & (reg_addr == irc_pkg::FLAG_ADDR);
    wire byte_mask = reg_wr & (reg_addr == irc_pkg::MASK_ADDR);
    wire byte_edge = reg_wr & (reg_addr == irc_pkg::EDGE_ADDR);
    wire bit_flag  = bit_wr & (bit_addr == irc_pkg::FLAG_ADDR);
    wire bit_mask  = bit_wr & (bit_addr == irc_pkg::MASK_ADDR);
    wire [NS-1:0] bit_onehot = NS'(1) << bit_sel;

    // the watchdog flag is frozen at zero outside interval mode
    wire [NS-1:0] wdt_keep = {{(NS-1){1'b1}}, wdt_interval_mode};

    // acknowledge and selection
    wire [NS-1:0] pending  = flag_r & ~mask_r;
    wire          mask_ok  = global_accept_bit & (|pending);
    wire          ack_mask = int_ack & (sel_r == irc_pkg::IRC_MASK);
    wire          ack_nmi  = int_ack & (sel_r == irc_pkg::IRC_NMI);
    wire [NS-1:0] ack_clr  = ack_mask ? (NS'(1) << sel_idx_r) : '0;

    always_comb
    begin
        flag_nxt = flag_r & ~ack_clr;
        if (byte_flag)
            flag_nxt = reg_wdata;
        else if (bit_flag)
            flag_nxt = bit_val ? (flag_nxt | bit_onehot)
                               : (flag_nxt & ~bit_onehot);
        // hardware set wins over any clear in the same cycle
        flag_nxt = (flag_nxt | src_evt) & wdt_keep;
    end

    always_comb
    begin
        mask_nxt = mask_r;
        if (byte_mask)
            mask_nxt = reg_wdata;
        else if (bit_mask)
            mask_nxt = bit_val ? (mask_r | bit_onehot) : (mask_r & ~bit_onehot);
    end

    assign nmi_pend_nxt = wdt_nmi_evt | (nmi_pend_r & ~ack_nmi);

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flag_r     <= irc_pkg::FLAG_RESET;
            mask_r     <= irc_pkg::MASK_RESET;
            edge_r     <= irc_pkg::EDGE_RESET;
            nmi_pend_r <= 1'b0;
        end
        else
        begin
            flag_r     <= flag_nxt;
            mask_r     <= mask_nxt;
            edge_r     <= byte_edge ? reg_wdata[irc_pkg::EDGE_LSB +: 2] : edge_r;
            nmi_pend_r <= nmi_pend_nxt;
        end
    end

    // selection is frozen between instruction end and acknowledge
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_r        <= irc_pkg::IRC_IDLE;
            sel_idx_r    <= 3'h0;
            int_vector_r <= 16'h0000;
        end
        else
        begin
            case (sel_r)
                irc_pkg::IRC_IDLE:
                begin
                    if (instr_done & nmi_pend_r)
                    begin
                        sel_r        <= irc_pkg::IRC_NMI;
                        int_vector_r <= irc_pkg::VEC_NMI;
                    end
                    else if (instr_done & mask_ok)
                    begin
                        sel_r        <= irc_pkg::IRC_MASK;
                        sel_idx_r    <= prio_pick(pending);
                        int_vector_r <= vec_of(prio_pick(pending));
                    end
                end
                irc_pkg::IRC_MASK, irc_pkg::IRC_NMI:
                begin
                    if (int_ack)
                        sel_r <= irc_pkg::IRC_IDLE;
                end
                default:
                    sel_r <= irc_pkg::IRC_IDLE;
            endcase
        end
    end

    assign int_req         = (sel_r != irc_pkg::IRC_IDLE);
    assign int_nmi         = (sel_r == irc_pkg::IRC_NMI);
    assign status_push     = int_ack & int_req;
    assign accept_clear    = int_ack & int_req;
    assign standby_release = nmi_pend_r | (|pending);

    // read port; unmapped addresses read zero
    wire [7:0] rd_mux = (reg_addr == irc_pkg::FLAG_ADDR) ? (flag_r & wdt_keep) :
                        (reg_addr == irc_pkg::MASK_ADDR) ? mask_r :
                        (reg_addr == irc_pkg::EDGE_ADDR) ? 8'(edge_r) << irc_pkg::EDGE_LSB :
                        8'h00;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata_r <= 8'h00;
        else if (reg_rd)
            reg_rdata_r <= rd_mux;
    end

    a_nmi_first: assert property (@(posedge mclk) disable iff (!rst_n)
        (sel_r == irc_pkg::IRC_IDLE) && instr_done && nmi_pend_r |=> int_nmi)
        else $error("nmi not selected first");
    a_nmi_vector: assert property (@(posedge mclk) disable iff (!rst_n)
        int_nmi |-> int_vector_r == 16'h0004)
        else $error("nmi vector wrong");
    a_standby_wake: assert property (@(posedge mclk) disable iff (!rst_n)
        watchdog_overflow_request && !wdt_interval_mode |=> standby_release)
        else $error("standby release missing");
    a_wdt_route: assert property (@(posedge mclk) disable iff (!rst_n)
        watchdog_overflow_request && !wdt_interval_mode
        |=> nmi_pend_r && !flag_r[irc_pkg::SRC_WDT])
        else $error("watchdog routed wrong");
    a_prio_pick: assert property (@(posedge mclk) disable iff (!rst_n)
        (sel_r == irc_pkg::IRC_IDLE) && instr_done && !nmi_pend_r && mask_ok
        |=> ((pending_q & ((8'h01 << sel_idx_r) - 8'h01)) == 8'h00) && pending_q[sel_idx_r])
        else $error("priority pick wrong");
    a_mask_vector: assert property (@(posedge mclk) disable iff (!rst_n)
        (sel_r == irc_pkg::IRC_MASK) |-> int_vector_r == 16'h0004 + 16'(sel_idx_r) * 16'h0002)
        else $error("maskable vector wrong");
    a_set_wins: assert property (@(posedge mclk) disable iff (!rst_n)
        serial_end_request |=> flag_r[irc_pkg::SRC_SER])
        else $error("serial event lost");
    a_ack_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        ack_mask && !src_evt[sel_idx_r] && !reg_wr && !bit_wr |=> !flag_r[$past(sel_idx_r)])
        else $error("acknowledged flag not cleared");
    a_no_accept: assert property (@(posedge mclk) disable iff (!rst_n)
        (sel_r == irc_pkg::IRC_IDLE) && !global_accept_bit && !nmi_pend_r |=> !int_req)
        else $error("request taken while disabled");
    a_wdt_frozen: assert property (@(posedge mclk) disable iff (!rst_n)
        !wdt_interval_mode |=> !flag_r[irc_pkg::SRC_WDT])
        else $error("watchdog flag set outside interval mode");

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            pending_q <= 8'h00;
        else
            pending_q <= pending;
    end

    c_nmi_taken: cover property (@(posedge mclk) disable iff (!rst_n) ack_nmi);
    c_mask_taken: cover property (@(posedge mclk) disable iff (!rst_n) ack_mask);
    c_two_pending: cover property (@(posedge mclk) disable iff (!rst_n)
        instr_done && mask_ok && $countones(pending) > 1);
endmodule
`default_nettype wire

// ==== bench/irc_cpu_model.sv ====
// irc_cpu_model: cpu core partner, instruction ends, acknowledges, accept bit.
// assumes the controller samples on rising edges; this model drives on falling.
`timescale 1ns/1ps
`default_nettype none
module irc_cpu_model
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // bench control
    input  wire logic       ei,
    input  wire logic [3:0] ack_wait,
    // controller side
    input  wire logic       int_req,
    input  wire logic       accept_clear,
    output logic            instr_done,
    output logic            int_ack,
    output logic            global_accept_bit
);
    logic       clr_seen;
    logic       ei_seen;
    logic [3:0] cnt;
    // accept_clear is combinational, so catch it where the controller samples it;
    // ei changes on the falling edge, so it is taken on the rising one to avoid a race
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clr_seen <= 1'b0;
            ei_seen <= 1'b0;
        end
        else
        begin
            clr_seen <= accept_clear;
            ei_seen <= ei;
        end
    end
    always @(negedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            instr_done <= 1'b0;
            int_ack <= 1'b0;
            cnt <= 4'h0;
            global_accept_bit <= 1'b0;
        end
        else
        begin
            // every other cycle, so selection sometimes has to wait
            instr_done <= !instr_done;
            int_ack <= int_req && !int_ack && cnt == ack_wait;
            cnt <= int_req ? cnt + 4'h1 : 4'h0;
            if (clr_seen)
                global_accept_bit <= 1'b0;
            else if (ei_seen)
                global_accept_bit <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== bench/test_interrupt_request_control.sv ====
// test_interrupt_request_control: self-checking bench for irc_top.
// assumes irc_cpu_model as the cpu core; sources are pulsed by the bench.
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_request_control;
    logic        mclk, rst_n, reg_wr, reg_rd, bit_wr, bit_val, wdt_mode, pin, ei;
    logic [15:0] reg_addr, bit_addr, int_vector_r;
    logic [7:0]  reg_wdata, reg_rdata_r, src;
    logic [2:0]  bit_sel;
    logic [3:0]  ack_wait;
    logic        instr_done, int_ack, gab, int_req, int_nmi, status_push, accept_clear, sby;
    int          err_count, n_tests, i;
    logic [1:0]  codes [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    always #4 mclk = !mclk;
    irc_top irc_top_i (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .bit_wr(bit_wr),
        .bit_addr(bit_addr), .bit_sel(bit_sel), .bit_val(bit_val),
        .watchdog_overflow_request(src[0]), .wdt_interval_mode(wdt_mode),
        .shared_port_pin(pin), .serial_end_request(src[2]), .watch_timer_request(src[3]),
        .timer_a_match_request(src[4]), .timer_b_match_request(src[5]),
        .key_return_request(src[6]), .watch_interval_request(src[7]),
        .global_accept_bit(gab), .instr_done(instr_done), .int_ack(int_ack),
        .int_req(int_req), .int_nmi(int_nmi), .int_vector_r(int_vector_r),
        .status_push(status_push), .accept_clear(accept_clear), .standby_release(sby));
    irc_cpu_model irc_cpu_model_i (.mclk(mclk), .rst_n(rst_n), .ei(ei), .ack_wait(ack_wait),
        .int_req(int_req), .accept_clear(accept_clear), .instr_done(instr_done),
        .int_ack(int_ack), .global_accept_bit(gab));
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge mclk);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask
    task automatic bw(input logic [15:0] a, input logic [2:0] s, input logic v);
        @(negedge mclk);
        {bit_addr, bit_sel, bit_val, bit_wr} = {a, s, v, 1'b1};
        @(negedge mclk);
        bit_wr = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(negedge mclk);
        {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge mclk);
        reg_rd = 1'b0;
        chk("reg_rdata_r", exp, reg_rdata_r);
    endtask
    task automatic pulse(input logic [7:0] s);
        @(negedge mclk);
        src = s;
        @(negedge mclk);
        src = 8'h00;
    endtask
    task automatic wait_int(input logic [15:0] vec, input logic nmi);
        int k;
        for (k = 0; k < 40 && int_req !== 1'b1; k++)
            @(negedge mclk);
        if (k == 40)
        begin
            err_count++;
            wrap_up();
        end
        chk("int_vector_r", vec, int_vector_r);
        chk("int_nmi", nmi, int_nmi);
        #1;
        for (k = 0; k < 40 && int_ack !== 1'b1; k++)
        begin
            @(negedge mclk);
            #1;
        end
        if (k == 40)
        begin
            err_count++;
            wrap_up();
        end
        chk("status_push", 1'b1, status_push);
        chk("accept_clear", 1'b1, accept_clear);
        @(negedge mclk);
        chk("int_req", 1'b0, int_req);
    endtask
    initial
    begin
        {mclk, rst_n, reg_wr, reg_rd, bit_wr, bit_val, pin, ei} = 8'h00;
        {reg_addr, bit_addr, reg_wdata, src, bit_sel, ack_wait} = '0;
        {err_count, n_tests, wdt_mode} = '0;
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        rst_n = 1'b1;
        rd(16'hffe0, 8'h00);
        rd(16'hffe4, 8'hff);
        rd(16'hff00, 8'h00);
        chk("standby_release", 1'b0, sby);
        // hardware keeps the watchdog flag clear while in watchdog mode
        wr(16'hffe0, 8'h01);
        rd(16'hffe0, 8'h00);
        wdt_mode = 1'b1;
        wr(16'hffe0, 8'hff);
        rd(16'hffe0, 8'hff);
        bw(16'hffe0, 3'h3, 1'b0);
        rd(16'hffe0, 8'hf7);
        wr(16'hffe0, 8'h00);
        rd(16'hffe0, 8'h00);
        // pin stays masked (reset ff) while its edge select changes
        for (i = 0; i < 4; i++)
        begin
            wr(16'hffec, {4'h0, codes[i], 2'h0});
            wr(16'hffe0, 8'h00);
            pin = 1'b1;
            rd(16'hffe0, {6'h00, codes[i] == 2'h1 || codes[i] == 2'h3, 1'b0});
            wr(16'hffe0, 8'h00);
            pin = 1'b0;
            rd(16'hffe0, {6'h00, codes[i] == 2'h0 || codes[i] == 2'h3, 1'b0});
        end
        wr(16'hffe0, 8'h00);
        wr(16'hffec, 8'h04);
        rd(16'hffec, 8'h04);
        pin = 1'b1;
        pulse(8'hfd);
        rd(16'hffe0, 8'hff);
        wr(16'hffe4, 8'h00);
        chk("standby_release", 1'b1, sby);
        for (i = 0; i < 8; i++)
        begin
            ack_wait = 4'(i);
            repeat (4) @(negedge mclk);
            chk("int_req", 1'b0, int_req);
            ei = 1'b1;
            @(negedge mclk);
            ei = 1'b0;
            wait_int(16'h0004 + 16'(2 * i), 1'b0);
            if (i == 0)
                rd(16'hffe0, 8'hfe);
        end
        wr(16'hffe4, 8'hff);
        bw(16'hffe0, 3'h4, 1'b1);
        ei = 1'b1;
        @(negedge mclk);
        ei = 1'b0;
        repeat (6) @(negedge mclk);
        chk("int_req", 1'b0, int_req);
        chk("standby_release", 1'b0, sby);
        bw(16'hffe4, 3'h4, 1'b0);
        wait_int(16'h000c, 1'b0);
        wr(16'hffe4, 8'hff);
        wdt_mode = 1'b0;
        pulse(8'h01);
        chk("standby_release", 1'b1, sby);
        wait_int(16'h0004, 1'b1);
        rd(16'hffe0, 8'h00);
        wrap_up();
    end
endmodule
`default_nettype wire
